// ===== src/frc_pkg.sv
// package for the flash read configuration register block
package frc_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses, AXI4-Lite)
	// ------------------------------------------------------------
	localparam logic [7:0] NV_OFFSET     = 8'h00;
	localparam logic [7:0] VOL_OFFSET    = 8'h04;
	localparam logic [7:0] CTRL_OFFSET   = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int IMP_LSB   = 5;
	localparam int WRAP_EN   = 4;
	localparam int ECC_BIT   = 3;
	localparam int DEEP_BIT  = 2;
	localparam int WLEN_LSB  = 0;
	localparam int CTRL_CS   = 0;
	localparam int CTRL_HRST = 1;
	localparam int CTRL_PWRON = 2;
	localparam int ST_DEEP   = 0;
	localparam int ST_ECCCHG = 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [2:0] IMP_RESET  = 3'h5;
	localparam logic       WRAP_RESET = 1'h0;
	localparam logic       ECC_RESET  = 1'h1;
	localparam logic       DEEP_RESET = 1'h0;
	localparam logic [1:0] WLEN_RESET = 2'h0;
	localparam logic [7:0] CFG_RESET  = 8'hA8;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		PWR_STANDBY   = 1'b0,
		PWR_DEEP_DOWN = 1'b1
	} frc_power_type;

	typedef struct packed {
		logic [2:0] driver_impedance_select;
		logic       wrap_burst_enable;
		logic       ecc_mode_select;
		logic       deep_sleep_at_poweron;
		logic [1:0] wrap_length_select;
	} frc_cfg_type;

	typedef struct packed {
		logic [6:0] impedance_ohms;
		logic       wrap_enable;
		logic [6:0] wrap_bytes;
		logic       ecc_double_detect;
	} frc_drive_type;

endpackage : frc_pkg

// ===== src/frc_block.sv
// flash read configuration register: non-volatile and volatile copies on AXI4-Lite
`timescale 1ns/1ps
module frc_block (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// axi4-lite write address
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	// axi4-lite write response
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	// axi4-lite read data
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// device-side pins
	input  wire logic                cs_n_pin,
	// decoded configuration to the array and io logic
	output frc_pkg::frc_drive_type   drive_out,
	output logic                     deep_power_down,
	output logic                     ecc_mode_changed
);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic [6:0] imp_ohms(input logic [2:0] s);
		unique case (s)
			3'h0: imp_ohms = 7'h2D;
			3'h1: imp_ohms = 7'h78;
			3'h2: imp_ohms = 7'h5A;
			3'h3: imp_ohms = 7'h3C;
			3'h4: imp_ohms = 7'h2D;
			3'h5: imp_ohms = 7'h1E;
			3'h6: imp_ohms = 7'h14;
			3'h7: imp_ohms = 7'h0F;
		endcase
	endfunction

	function automatic logic [6:0] wrap_bytes(input logic [1:0] s);
		wrap_bytes = 7'(7'h08 << s);
	endfunction

	// merge byte lane 0 only; the registers are 8 bits wide
	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] be);
		lane0 = be[0] ? d[7:0] : old;
	endfunction

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	logic cs_meta_q, cs_sync_q, cs_prev_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cs_meta_q <= 1'b1;
			cs_sync_q <= 1'b1;
			cs_prev_q <= 1'b1;
		end else begin
			cs_meta_q <= cs_n_pin;
			cs_sync_q <= cs_meta_q;
			cs_prev_q <= cs_sync_q;
		end
	end
	// pulse detected on the rising edge that ends a low pulse
	wire cs_pulse = cs_sync_q & ~cs_prev_q;

	// ------------------------------------------------------------
	// axi write channel
	// ------------------------------------------------------------
	logic       aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d;
	logic       wr_fire;

	assign s_axi_awready = ~aw_have_q & ~bvalid_q;
	assign s_axi_wready  = ~w_have_q & ~bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		wr_fire   = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (aw_have_q && w_have_q) begin
			wr_fire   = 1'b1;
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			unique case (awaddr_q)
				frc_pkg::NV_OFFSET, frc_pkg::VOL_OFFSET, frc_pkg::CTRL_OFFSET: bresp_d = frc_pkg::RESP_OKAY;
				default: bresp_d = frc_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	frc_pkg::frc_cfg_type nv_q, nv_d, vol_q, vol_d;
	logic                 loaded_q, loaded_d;
	logic                 eccchg_q, eccchg_d;
	frc_pkg::frc_power_type pwr_q, pwr_d;
	logic [7:0]           wbyte;

	always_comb begin
		nv_d     = nv_q;
		vol_d    = vol_q;
		loaded_d = 1'b1;
		eccchg_d = eccchg_q;
		pwr_d    = pwr_q;
		wbyte    = 8'h00;
		// first cycle after reset: copy non-volatile into volatile
		if (!loaded_q) begin
			vol_d = nv_q;
			pwr_d = nv_q.deep_sleep_at_poweron ? frc_pkg::PWR_DEEP_DOWN : frc_pkg::PWR_STANDBY;
		end else if (wr_fire) begin
			unique case (awaddr_q)
				frc_pkg::NV_OFFSET: begin
					nv_d = frc_pkg::frc_cfg_type'(lane0(nv_q, wdata_q, wstrb_q));
				end
				frc_pkg::VOL_OFFSET: begin
					wbyte = lane0(vol_q, wdata_q, wstrb_q);
					vol_d = frc_pkg::frc_cfg_type'(wbyte);
					// power-on choice is read-only in the volatile copy
					vol_d.deep_sleep_at_poweron = vol_q.deep_sleep_at_poweron;
					// stored check bits no longer match; host must reprogram
					if (wbyte[frc_pkg::ECC_BIT] != vol_q.ecc_mode_select)
						eccchg_d = 1'b1;
				end
				frc_pkg::CTRL_OFFSET: begin
					if (wstrb_q[0] && wdata_q[frc_pkg::CTRL_CS])
						eccchg_d = 1'b0;
					if (wstrb_q[0] && wdata_q[frc_pkg::CTRL_HRST])
						pwr_d = frc_pkg::PWR_STANDBY;
					// power cycle that keeps the non-volatile copy; rst restores factory values,
					// so only this path shows the power-on choice of a programmed copy.
					// bus spacing keeps any write out of the reload cycle
					if (wstrb_q[0] && wdata_q[frc_pkg::CTRL_PWRON])
						loaded_d = 1'b0;
				end
				default: ;
			endcase
		end
		if (loaded_q && pwr_q == frc_pkg::PWR_DEEP_DOWN && cs_pulse)
			pwr_d = frc_pkg::PWR_STANDBY;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			nv_q     <= frc_pkg::CFG_RESET;
			vol_q    <= frc_pkg::CFG_RESET;
			loaded_q <= 1'b0;
			eccchg_q <= 1'b0;
			pwr_q    <= frc_pkg::PWR_STANDBY;
		end else begin
			nv_q     <= nv_d;
			vol_q    <= vol_d;
			loaded_q <= loaded_d;
			eccchg_q <= eccchg_d;
			pwr_q    <= pwr_d;
		end
	end

	// ------------------------------------------------------------
	// decoded outputs
	// ------------------------------------------------------------
	frc_pkg::frc_drive_type drive_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			drive_q <= '0;
		end else begin
			drive_q.impedance_ohms    <= imp_ohms(vol_q.driver_impedance_select);
			drive_q.wrap_enable       <= vol_q.wrap_burst_enable;
			drive_q.wrap_bytes        <= wrap_bytes(vol_q.wrap_length_select);
			drive_q.ecc_double_detect <= vol_q.ecc_mode_select;
		end
	end
	assign drive_out        = drive_q;
	assign deep_power_down  = (pwr_q == frc_pkg::PWR_DEEP_DOWN);
	assign ecc_mode_changed = eccchg_q;

	// ------------------------------------------------------------
	// axi read channel
	// ------------------------------------------------------------
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;

	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = frc_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				frc_pkg::NV_OFFSET:     rdata_d = {24'h000000, nv_q};
				frc_pkg::VOL_OFFSET:    rdata_d = {24'h000000, vol_q};
				frc_pkg::CTRL_OFFSET:   rdata_d = 32'h0000_0000;
				frc_pkg::STATUS_OFFSET: rdata_d = {30'h0, eccchg_q, deep_power_down};
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = frc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= 2'h0;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_vol_write;
		wr_fire && loaded_q && awaddr_q == frc_pkg::VOL_OFFSET && wstrb_q[0];
	endsequence

	a_imp_decode: assert property (@(posedge clk_sys) disable iff (rst)
		loaded_q |=> drive_out.impedance_ohms == imp_ohms($past(vol_q.driver_impedance_select)))
		else $error("impedance decode mismatch");
	a_reset_fields: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(rst) |-> nv_q.driver_impedance_select == frc_pkg::IMP_RESET
			&& vol_q.driver_impedance_select == frc_pkg::IMP_RESET)
		else $error("impedance copies not at factory value");
	a_wrap_follow: assert property (@(posedge clk_sys) disable iff (rst)
		s_vol_write |-> ##2 drive_out.wrap_enable == $past(wdata_q[frc_pkg::WRAP_EN], 2))
		else $error("wrap enable did not follow write");
	a_wrap_len: assert property (@(posedge clk_sys) disable iff (rst)
		s_vol_write |-> ##2 drive_out.wrap_bytes == 7'(7'h08 << $past(wdata_q[1:0], 2)))
		else $error("wrap length mismatch");
	a_ecc_follow: assert property (@(posedge clk_sys) disable iff (rst)
		s_vol_write |-> ##2 drive_out.ecc_double_detect == $past(wdata_q[frc_pkg::ECC_BIT], 2))
		else $error("ecc mode mismatch");
	a_deep_ro: assert property (@(posedge clk_sys) disable iff (rst)
		s_vol_write |=> vol_q.deep_sleep_at_poweron == $past(vol_q.deep_sleep_at_poweron))
		else $error("volatile power-on bit changed");
	a_deep_wake: assert property (@(posedge clk_sys) disable iff (rst)
		(loaded_q && deep_power_down && cs_pulse) |=> !deep_power_down)
		else $error("chip-select pulse did not wake");
	a_nv_load: assert property (@(posedge clk_sys) disable iff (rst)
		!loaded_q |=> vol_q == $past(nv_q) && deep_power_down == $past(nv_q.deep_sleep_at_poweron))
		else $error("volatile copy not loaded");
	a_nv_kept: assert property (@(posedge clk_sys) disable iff (rst)
		s_vol_write |=> nv_q == $past(nv_q))
		else $error("non-volatile changed on volatile write");

endmodule // frc_block

// ===== dv/frc_host_pins.sv
// host-side pin model: chip select and array bookkeeping
`timescale 1ns/1ps
module frc_host_pins (
	// clock
	input  wire logic clk_sys,
	// pins
	output logic      cs_n_pin,
	// status from device
	input  wire logic ecc_mode_changed
);
	logic array_stale;

	initial begin
		cs_n_pin    = 1'b1;
		array_stale = 1'b0;
	end

	// --------------------------------
	// chip-select wake pulse
	// --------------------------------
	task automatic cs_pulse(input int len);
		@(posedge clk_sys);
		cs_n_pin <= 1'b0;
		repeat (len) @(posedge clk_sys);
		cs_n_pin <= 1'b1;
	endtask

	// stored check bits no longer match: array must be erased and rewritten
	always @(posedge clk_sys) begin
		if (ecc_mode_changed === 1'b1) begin
			array_stale <= 1'b1;
		end
	end
endmodule // frc_host_pins

// ===== dv/frc_block_test.sv
// self-checking bench for the configuration register block
`timescale 1ns/1ps
module frc_block_test;
	logic                  clk_sys = 1'b0;
	logic                  rst = 1'b1;
	logic [7:0]            s_axi_awaddr = 8'h00;
	logic                  s_axi_awvalid = 1'b0;
	logic                  s_axi_awready;
	logic [31:0]           s_axi_wdata = 32'h0;
	logic [3:0]            s_axi_wstrb = 4'hF;
	logic                  s_axi_wvalid = 1'b0;
	logic                  s_axi_wready;
	logic [1:0]            s_axi_bresp;
	logic                  s_axi_bvalid;
	logic                  s_axi_bready = 1'b0;
	logic [7:0]            s_axi_araddr = 8'h00;
	logic                  s_axi_arvalid = 1'b0;
	logic                  s_axi_arready;
	logic [31:0]           s_axi_rdata;
	logic [1:0]            s_axi_rresp;
	logic                  s_axi_rvalid;
	logic                  s_axi_rready = 1'b0;
	logic                  cs_n_pin;
	frc_pkg::frc_drive_type drive_out;
	logic                  deep_power_down;
	logic                  ecc_mode_changed;
	int                    num_errors = 0;
	int                    samples_checked = 0;
	localparam logic [6:0] OHM [0:7] = '{7'h2D, 7'h78, 7'h5A, 7'h3C, 7'h2D, 7'h1E, 7'h14, 7'h0F};

	always #4 clk_sys = ~clk_sys;

	frc_block i_dut (
		.clk_sys          (clk_sys),
		.rst              (rst),
		.s_axi_awaddr     (s_axi_awaddr),
		.s_axi_awvalid    (s_axi_awvalid),
		.s_axi_awready    (s_axi_awready),
		.s_axi_wdata      (s_axi_wdata),
		.s_axi_wstrb      (s_axi_wstrb),
		.s_axi_wvalid     (s_axi_wvalid),
		.s_axi_wready     (s_axi_wready),
		.s_axi_bresp      (s_axi_bresp),
		.s_axi_bvalid     (s_axi_bvalid),
		.s_axi_bready     (s_axi_bready),
		.s_axi_araddr     (s_axi_araddr),
		.s_axi_arvalid    (s_axi_arvalid),
		.s_axi_arready    (s_axi_arready),
		.s_axi_rdata      (s_axi_rdata),
		.s_axi_rresp      (s_axi_rresp),
		.s_axi_rvalid     (s_axi_rvalid),
		.s_axi_rready     (s_axi_rready),
		.cs_n_pin         (cs_n_pin),
		.drive_out        (drive_out),
		.deep_power_down  (deep_power_down),
		.ecc_mode_changed (ecc_mode_changed)
	);
	frc_host_pins i_host (
		.clk_sys          (clk_sys),
		.cs_n_pin         (cs_n_pin),
		.ecc_mode_changed (ecc_mode_changed)
	);

	// --------------------------------
	// checks and bus tasks
	// --------------------------------
	task automatic results;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic hang;
		num_errors++;
		$display("MISMATCH %0t bus wait ran out", $time);
		results();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tw, tb;
		logic [1:0] rb;
		@(posedge clk_sys);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk_sys);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			rb = s_axi_bresp;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) begin
				s_axi_bready <= 1'b0;
				chk(rb, r);
				return;
			end
		end
		hang();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tr;
		@(posedge clk_sys);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk_sys);
			ta = s_axi_arready;
			tr = s_axi_rvalid;
			if (tr) begin
				chk(s_axi_rdata, d);
				chk(s_axi_rresp, r);
			end
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	task automatic chk_drive(input int i, input logic w, input logic [1:0] l, input logic e);
		@(negedge clk_sys);
		chk(drive_out, {OHM[i], w, 7'(8 << l), e});
	endtask

	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_reset;
		rd(frc_pkg::NV_OFFSET, 32'hA8, frc_pkg::RESP_OKAY);
		rd(frc_pkg::VOL_OFFSET, 32'hA8, frc_pkg::RESP_OKAY);
		chk_drive(5, 1'b0, 2'h0, 1'b1);
		chk(deep_power_down, 1'b0);
	endtask

	// every impedance code with wrap on; the read-only bit is written 1
	task automatic t_fields;
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			v = {3'(i), 3'h6, 2'(i)};
			wr(frc_pkg::VOL_OFFSET, {24'h0, v | 8'h04}, frc_pkg::RESP_OKAY);
			rd(frc_pkg::VOL_OFFSET, {24'h0, v}, frc_pkg::RESP_OKAY);
			chk_drive(i, 1'b1, 2'(i), 1'b1);
		end
		rd(frc_pkg::NV_OFFSET, 32'hA8, frc_pkg::RESP_OKAY);
	endtask

	task automatic t_ecc;
		wr(frc_pkg::VOL_OFFSET, 32'hA0, frc_pkg::RESP_OKAY);
		chk_drive(5, 1'b0, 2'h0, 1'b0);
		chk(ecc_mode_changed, 1'b1);
		chk(i_host.array_stale, 1'b1);
		rd(frc_pkg::STATUS_OFFSET, 32'h2, frc_pkg::RESP_OKAY);
		wr(frc_pkg::CTRL_OFFSET, 32'h1, frc_pkg::RESP_OKAY);
		rd(frc_pkg::STATUS_OFFSET, 32'h0, frc_pkg::RESP_OKAY);
		chk(ecc_mode_changed, 1'b0);
	endtask

	// programmed power-on choice, then both ways out of deep power down
	task automatic t_nv_and_power;
		wr(frc_pkg::NV_OFFSET, 32'hAC, frc_pkg::RESP_OKAY);
		rd(frc_pkg::NV_OFFSET, 32'hAC, frc_pkg::RESP_OKAY);
		rd(frc_pkg::VOL_OFFSET, 32'hA0, frc_pkg::RESP_OKAY);
		wr(frc_pkg::CTRL_OFFSET, 32'h4, frc_pkg::RESP_OKAY);
		rd(frc_pkg::VOL_OFFSET, 32'hAC, frc_pkg::RESP_OKAY);
		rd(frc_pkg::STATUS_OFFSET, 32'h1, frc_pkg::RESP_OKAY);
		chk_drive(5, 1'b0, 2'h0, 1'b1);
		i_host.cs_pulse(3);
		@(negedge clk_sys);
		chk(deep_power_down, 1'b1);
		repeat (4) @(negedge clk_sys);
		chk(deep_power_down, 1'b0);
		rd(frc_pkg::STATUS_OFFSET, 32'h0, frc_pkg::RESP_OKAY);
		wr(frc_pkg::CTRL_OFFSET, 32'h4, frc_pkg::RESP_OKAY);
		rd(frc_pkg::STATUS_OFFSET, 32'h1, frc_pkg::RESP_OKAY);
		wr(frc_pkg::CTRL_OFFSET, 32'h2, frc_pkg::RESP_OKAY);
		rd(frc_pkg::STATUS_OFFSET, 32'h0, frc_pkg::RESP_OKAY);
	endtask

	task automatic t_refused;
		rd(8'h10, 32'h0, frc_pkg::RESP_SLVERR);
		wr(frc_pkg::STATUS_OFFSET, 32'h3, frc_pkg::RESP_SLVERR);
		rd(frc_pkg::CTRL_OFFSET, 32'h0, frc_pkg::RESP_OKAY);
		// byte lane 0 off: answered, nothing changes
		@(posedge clk_sys);
		s_axi_wstrb <= 4'hE;
		wr(frc_pkg::VOL_OFFSET, 32'h13, frc_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(frc_pkg::VOL_OFFSET, 32'hAC, frc_pkg::RESP_OKAY);
	endtask

	// second reset in mid-run brings the volatile copy back
	task automatic t_rereset;
		wr(frc_pkg::VOL_OFFSET, 32'hF3, frc_pkg::RESP_OKAY);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd(frc_pkg::VOL_OFFSET, 32'hA8, frc_pkg::RESP_OKAY);
		chk_drive(5, 1'b0, 2'h0, 1'b1);
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_fields();
		t_ecc();
		t_nv_and_power();
		t_refused();
		t_rereset();
		results();
	end
endmodule // frc_block_test
